// ### core/gp_pin_sync.sv
/*
  Input synchroniser for every pin of the port: a latch that is open while
  the clock is high, followed by the sample flip-flop on the rising edge.
  Assumes the input is already clamped and comes from outside the clock domain.
*/
`timescale 1ns/100ps

module gp_pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sample
);

  logic [WIDTH-1:0] latch_q;
  logic [WIDTH-1:0] sample_q;

  // Latch holds from the falling edge so the flop never sees a moving input
  always_latch begin
    if (aclk) begin
      latch_q <= async_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_q <= '0;
    end else begin
      sample_q <= latch_q;
    end
  end

  assign sample = sample_q;

endmodule

// ### core/gp_port.sv
/*
  General-purpose digital I/O port: per-pin direction, drive/pull-up and
  synchronised input sample, global pull-up disable, sleep input clamp and
  external pin change flags, reached over an AXI4-Lite slave.
  Assumes an external pad cell that resolves pad_out/pad_oe/pad_pullup.
*/
// Notes on behaviour
// - Direction bit one makes the pin an output, zero an input.
// - Input pin with drive bit one gets pull-up; otherwise pull-up off.
// - All pins go high-impedance at once while reset is asserted.
// - Output pin drives high when drive bit is one, low when zero.
// - Global pull-up disable keeps every pull-up off; such inputs float.
// - Pin level readable via input sample, any direction, through synchroniser.
// - Latch open on clock high, sample on next rising edge.
// - Written drive value appears in input sample one clock later.
// - Deep sleep modes clamp digital inputs low before the synchroniser.
// - Pins with external interrupt enabled are never clamped.
// - Clamp release on a high any-change pin sets its flag.
// - Pull-ups stay off while reset is asserted.
// - No clamp in reset, active or idle operation.
// - Pull-up only when direction zero, drive one, disable zero.
// - Sense setting zero-one flags any change of the pin.
`timescale 1ns/100ps

module gp_port #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [WIDTH-1:0] pad_in,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe,
  output logic [WIDTH-1:0] pad_pullup
);

  // Sense field holds two bits per pin in one 32-bit word
  if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
    $error("gp_port: WIDTH must be 1 to 16");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic gp_pkg::gp_idx_t reg_index(input logic [31:0] addr);
    logic [31:0] a;
    a = {addr[31:2], 2'h0};
    if (a == gp_pkg::OFS_DIRECTION) begin
      return gp_pkg::GP_IDX_DIRECTION;
    end else if (a == gp_pkg::OFS_DRIVE) begin
      return gp_pkg::GP_IDX_DRIVE;
    end else if (a == gp_pkg::OFS_INPUT) begin
      return gp_pkg::GP_IDX_INPUT;
    end else if (a == gp_pkg::OFS_CONTROL) begin
      return gp_pkg::GP_IDX_CONTROL;
    end else if (a == gp_pkg::OFS_INT_ENABLE) begin
      return gp_pkg::GP_IDX_INT_ENABLE;
    end else if (a == gp_pkg::OFS_INT_SENSE) begin
      return gp_pkg::GP_IDX_INT_SENSE;
    end else if (a == gp_pkg::OFS_INT_FLAG) begin
      return gp_pkg::GP_IDX_INT_FLAG;
    end else begin
      return gp_pkg::GP_IDX_NONE;
    end
  endfunction

  // Byte-lane merge of a write into an old register word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // Write channel
  // ****************************************
  logic awready_q, wready_q, aw_have_q, w_have_q, bvalid_q, wr_fire;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  gp_pkg::gp_idx_t wr_idx;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_idx = reg_index(awaddr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= gp_pkg::RESET_WORD;
      wdata_q <= gp_pkg::RESET_WORD;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= gp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end else if (!aw_have_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end else if (!w_have_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_idx == gp_pkg::GP_IDX_NONE) ? gp_pkg::RESP_SLVERR : gp_pkg::RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pin configuration registers
  // ****************************************
  logic [WIDTH-1:0] dir_q, drive_q, int_en_q, flag_q;
  logic pud_q;
  gp_pkg::gp_sleep_t sleep_q;
  logic [2*WIDTH-1:0] sense_q;
  logic [31:0] wr_word;

  always_comb begin
    wr_word = gp_pkg::RESET_WORD;
    case (wr_idx)
      gp_pkg::GP_IDX_DIRECTION: wr_word = 32'(dir_q);
      gp_pkg::GP_IDX_DRIVE: wr_word = 32'(drive_q);
      gp_pkg::GP_IDX_CONTROL: wr_word = 32'({sleep_q, pud_q});
      gp_pkg::GP_IDX_INT_ENABLE: wr_word = 32'(int_en_q);
      gp_pkg::GP_IDX_INT_SENSE: wr_word = 32'(sense_q);
      default: wr_word = gp_pkg::RESET_WORD;
    endcase
    wr_word = merge(wr_word, wdata_q, wstrb_q);
  end

  // Each bit of these words belongs to one pin only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= '0;
      drive_q <= '0;
    end else if (wr_fire) begin
      if (wr_idx == gp_pkg::GP_IDX_DIRECTION) begin
        dir_q <= wr_word[WIDTH-1:0];
      end else if (wr_idx == gp_pkg::GP_IDX_DRIVE) begin
        drive_q <= wr_word[WIDTH-1:0];
      end
    end
  end

  // Reset leaves the port awake with pull-ups allowed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pud_q <= 1'b0;
      sleep_q <= gp_pkg::GP_SLEEP_ACTIVE;
    end else if (wr_fire && wr_idx == gp_pkg::GP_IDX_CONTROL) begin
      pud_q <= wr_word[gp_pkg::CTRL_PUD_BIT];
      sleep_q <= gp_pkg::gp_sleep_t'(wr_word[gp_pkg::CTRL_SLEEP_LSB +: gp_pkg::CTRL_SLEEP_W]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_en_q <= '0;
      sense_q <= '0;
    end else if (wr_fire) begin
      if (wr_idx == gp_pkg::GP_IDX_INT_ENABLE) begin
        int_en_q <= wr_word[WIDTH-1:0];
      end else if (wr_idx == gp_pkg::GP_IDX_INT_SENSE) begin
        sense_q <= wr_word[2*WIDTH-1:0];
      end
    end
  end

  // ****************************************
  // Pad control
  // ****************************************
  // Reset gates the pad enables directly so the pins float even with no clock
  // edge; this is the one place outputs are not pure flip-flops.
  assign pad_oe = dir_q & {WIDTH{aresetn}};
  assign pad_out = drive_q;
  assign pad_pullup = ~dir_q & drive_q & {WIDTH{~pud_q & aresetn}};

  // ****************************************
  // Input path
  // ****************************************
  logic deep_sleep;
  logic [WIDTH-1:0] din_en, clamped_in, sample, sample_prev_q;

  always_comb begin
    case (sleep_q)
      gp_pkg::GP_SLEEP_POWER_DOWN,
      gp_pkg::GP_SLEEP_POWER_SAVE,
      gp_pkg::GP_SLEEP_STANDBY,
      gp_pkg::GP_SLEEP_EXT_STANDBY: deep_sleep = aresetn;
      default: deep_sleep = 1'b0;
    endcase
  end

  assign din_en = ~{WIDTH{deep_sleep}} | int_en_q;
  assign clamped_in = pad_in & din_en;

  gp_pin_sync #(
    .WIDTH(WIDTH)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(clamped_in),
    .sample(sample)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_prev_q <= '0;
    end else begin
      sample_prev_q <= sample;
    end
  end

  // ****************************************
  // Pin change flags
  // ****************************************
  // Flags see the clamped level, so a high pin released from the clamp counts
  // as a change. A new event beats a clear in the same cycle.
  logic [WIDTH-1:0] flag_set, flag_clr, level_mode;

  always_comb begin
    flag_set = '0;
    level_mode = '0;
    for (int i = 0; i < WIDTH; i++) begin
      case (sense_q[gp_pkg::SENSE_W*i +: gp_pkg::SENSE_W])
        gp_pkg::SENSE_ANY_CHANGE: flag_set[i] = sample[i] ^ sample_prev_q[i];
        gp_pkg::SENSE_FALLING: flag_set[i] = sample_prev_q[i] & ~sample[i];
        gp_pkg::SENSE_RISING: flag_set[i] = ~sample_prev_q[i] & sample[i];
        default: level_mode[i] = 1'b1;
      endcase
    end
  end

  assign flag_clr = (wr_fire && wr_idx == gp_pkg::GP_IDX_INT_FLAG) ?
                    (wdata_q[WIDTH-1:0] & wr_word[WIDTH-1:0]) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= ((flag_q & ~flag_clr) | flag_set) & ~level_mode;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q, rd_word;
  logic [1:0] rresp_q;
  gp_pkg::gp_idx_t rd_idx;
  assign rd_idx = reg_index(s_axi_araddr);

  always_comb begin
    case (rd_idx)
      gp_pkg::GP_IDX_DIRECTION: rd_word = 32'(dir_q);
      gp_pkg::GP_IDX_DRIVE: rd_word = 32'(drive_q);
      gp_pkg::GP_IDX_INPUT: rd_word = 32'(sample);
      gp_pkg::GP_IDX_CONTROL: rd_word = 32'({sleep_q, pud_q});
      gp_pkg::GP_IDX_INT_ENABLE: rd_word = 32'(int_en_q);
      gp_pkg::GP_IDX_INT_SENSE: rd_word = 32'(sense_q);
      gp_pkg::GP_IDX_INT_FLAG: rd_word = 32'(flag_q);
      default: rd_word = gp_pkg::RESET_WORD;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= gp_pkg::RESET_WORD;
      rresp_q <= gp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= (rd_idx == gp_pkg::GP_IDX_NONE) ? gp_pkg::RESP_SLVERR : gp_pkg::RESP_OKAY;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

// ### pkg/gp_pkg.sv
/*
  Shared constants for the general-purpose I/O port: register offsets, field
  positions, reset values, sleep mode and interrupt sense encodings.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package gp_pkg;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [31:0] OFS_DIRECTION = 32'h0000_0000;
  localparam logic [31:0] OFS_DRIVE = 32'h0000_0004;
  localparam logic [31:0] OFS_INPUT = 32'h0000_0008;
  localparam logic [31:0] OFS_CONTROL = 32'h0000_000c;
  localparam logic [31:0] OFS_INT_ENABLE = 32'h0000_0010;
  localparam logic [31:0] OFS_INT_SENSE = 32'h0000_0014;
  localparam logic [31:0] OFS_INT_FLAG = 32'h0000_0018;
  localparam int unsigned ADDR_DECODE_BITS = 5;

  // Register indices as produced by the address decoder
  typedef enum logic [2:0] {
    GP_IDX_DIRECTION,
    GP_IDX_DRIVE,
    GP_IDX_INPUT,
    GP_IDX_CONTROL,
    GP_IDX_INT_ENABLE,
    GP_IDX_INT_SENSE,
    GP_IDX_INT_FLAG,
    GP_IDX_NONE
  } gp_idx_t;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int unsigned CTRL_PUD_BIT = 0;
  localparam int unsigned CTRL_SLEEP_LSB = 1;
  localparam int unsigned CTRL_SLEEP_W = 3;

  typedef enum logic [2:0] {
    GP_SLEEP_ACTIVE,
    GP_SLEEP_IDLE,
    GP_SLEEP_ADC_NOISE,
    GP_SLEEP_POWER_DOWN,
    GP_SLEEP_POWER_SAVE,
    GP_SLEEP_STANDBY,
    GP_SLEEP_EXT_STANDBY
  } gp_sleep_t;

  // Two sense bits per pin
  localparam int unsigned SENSE_W = 2;
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_ANY_CHANGE = 2'h1;
  localparam logic [1:0] SENSE_FALLING = 2'h2;
  localparam logic [1:0] SENSE_RISING = 2'h3;

  // ****************************************
  // Bus answers and reset values
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

// ### sim/gp_pad_model.sv
/*
  Pad model for gp_port: resolves each pin from the port, an outside driver and
  the pull-up. Assumes the bench drives ext_val/ext_en; a pin nobody holds floats.
*/
`timescale 1ns/100ps

module gp_pad_model #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic aclk,
  input wire logic [WIDTH-1:0] pad_out,
  input wire logic [WIDTH-1:0] pad_oe,
  input wire logic [WIDTH-1:0] pad_pullup,
  input wire logic [WIDTH-1:0] ext_val,
  input wire logic [WIDTH-1:0] ext_en,
  output logic [WIDTH-1:0] pad_in
);
  // A floating pin toggles so that no test can lean on a settled unknown
  logic [WIDTH-1:0] float_q = '0;

  always_ff @(posedge aclk) begin
    float_q <= ~float_q;
  end

  // Port driver wins, then the outside driver, then the pull-up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
    | (~pad_oe & ~ext_en & (pad_pullup | float_q));
endmodule

// ### sim/gp_port_properties.sv
/*
  Checker for gp_port: bus and pad relations seen at the top ports only.
  Assumes the bench writes whole words; partial strobes are left unchecked.
*/
`timescale 1ns/100ps

module gp_port_chk #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [WIDTH-1:0] pad_in,
  input wire logic [WIDTH-1:0] pad_out,
  input wire logic [WIDTH-1:0] pad_oe,
  input wire logic [WIDTH-1:0] pad_pullup
);
  logic [31:0] aw_q, wd_q, ar_q;
  logic [3:0] ws_q;
  logic bv_q, pud_q, deep_q;
  logic b_new, ctl_wr, dir_wr, pud_now;

  // ****************************************
  // Shadow of what software wrote
  // ****************************************
  // The register lands at the edge that raises bvalid, so the shadow is bypassed then
  assign b_new = s_axi_bvalid & ~bv_q;
  assign ctl_wr = b_new && aw_q == gp_pkg::OFS_CONTROL && ws_q == 4'hf;
  assign dir_wr = b_new && aw_q == gp_pkg::OFS_DIRECTION && ws_q == 4'hf;
  assign pud_now = ctl_wr ? wd_q[gp_pkg::CTRL_PUD_BIT] : pud_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= '0;
      wd_q <= '0;
      ar_q <= '0;
      ws_q <= '0;
      bv_q <= 1'b0;
      pud_q <= 1'b0;
      deep_q <= 1'b0;
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        ar_q <= s_axi_araddr;
      end
      if (ctl_wr) begin
        pud_q <= wd_q[gp_pkg::CTRL_PUD_BIT];
        deep_q <= wd_q[3:1] >= 3'h3 && wd_q[3:1] <= 3'h6;
      end
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_oe_in_reset: assert property (disable iff (1'b0) !aresetn |-> pad_oe == '0)
    else $error("pad_oe high during reset");
  a_pullup_in_reset: assert property (disable iff (1'b0) !aresetn |-> pad_pullup == '0)
    else $error("pad_pullup high during reset");
  a_pullup_not_output: assert property ((pad_oe & pad_pullup) == '0)
    else $error("pull-up on a driven pin");
  a_pullup_formula: assert property (pad_pullup == (~pad_oe & pad_out & {WIDTH{~pud_now}}))
    else $error("pull-up does not follow direction, drive and disable");
  a_dir_to_oe: assert property (dir_wr |-> pad_oe == wd_q[WIDTH-1:0])
    else $error("pad_oe differs from written direction");
  a_drive_to_out: assert property (b_new && aw_q == gp_pkg::OFS_DRIVE && ws_q == 4'hf
    |-> pad_out == wd_q[WIDTH-1:0]) else $error("pad_out differs from written drive");
  a_dir_keeps_out: assert property (dir_wr |-> $stable(pad_out))
    else $error("direction write moved pad_out");
  a_input_reads_pin: assert property ($stable(pad_in) [*4] ##0 ($rose(s_axi_rvalid)
    && ar_q == gp_pkg::OFS_INPUT && !deep_q) |-> s_axi_rdata[WIDTH-1:0] == pad_in)
    else $error("input read differs from steady pin level");

  c_pullup_on: cover property (|pad_pullup);
  c_input_read: cover property ($rose(s_axi_rvalid) && ar_q == gp_pkg::OFS_INPUT);
  c_dir_write: cover property (dir_wr);
endmodule

bind gp_port gp_port_chk #(.WIDTH(WIDTH)) u_gp_port_chk (.*);

// ### sim/testbench.sv
/*
  Testbench for gp_port: AXI4-Lite master tasks and one task per scenario.
  Assumes the checker is attached by its own bind and the pad model below.
*/
`timescale 1ns/100ps

module testbench;
  localparam int unsigned W = 8;
  logic aclk;
  logic aresetn;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [W-1:0] pad_in, pad_out, pad_oe, pad_pullup, ext_val, ext_en;
  int bad_count;
  int tests_run;

  gp_port #(.WIDTH(W)) u_gp_port (.*);
  gp_pad_model #(.WIDTH(W)) u_gp_pad_model (.*);

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic rdr(input logic [31:0] a, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
    rdr(a, gp_pkg::RESP_OKAY);
    chk(n, e, rd);
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_vals();
    logic [31:0] offs[6] = '{32'h0, 32'h4, 32'hc, 32'h10, 32'h14, 32'h18};
    foreach (offs[i]) rchk("reset value", offs[i], 32'h0);
    chk("idle pullup", 32'h0, 32'(pad_pullup));
  endtask

  task automatic t_pin_table();
    logic [W-1:0] m;
    ext_en <= 8'h30;
    ext_val <= 8'h20;
    for (int p = 0; p < 2; p++) begin
      // Disabled pull-ups leave pins 6 and 7 floating, so they are masked
      m = p ? 8'h3f : 8'hff;
      wr(gp_pkg::OFS_CONTROL, 32'(p), gp_pkg::RESP_OKAY);
      wr(gp_pkg::OFS_DRIVE, 32'hc3, gp_pkg::RESP_OKAY);
      wr(gp_pkg::OFS_DIRECTION, 32'h0f, gp_pkg::RESP_OKAY);
      #1;
      chk("pad_oe", 32'h0f, 32'(pad_oe));
      chk("pad_out", 32'h03, 32'(pad_out & pad_oe));
      chk("pad_pullup", p ? 32'h0 : 32'hc0, 32'(pad_pullup));
      rdr(gp_pkg::OFS_INPUT, gp_pkg::RESP_OKAY);
      chk("input", 32'(8'he3 & m), rd & 32'(m));
      wr(gp_pkg::OFS_DRIVE, 32'hca, gp_pkg::RESP_OKAY);
      rdr(gp_pkg::OFS_INPUT, gp_pkg::RESP_OKAY);
      chk("readback", 32'(8'hea & m), rd & 32'(m));
      wr(gp_pkg::OFS_DIRECTION, 32'h0, gp_pkg::RESP_OKAY);
      wr(gp_pkg::OFS_DRIVE, 32'h0, gp_pkg::RESP_OKAY);
    end
    wr(gp_pkg::OFS_CONTROL, 32'h0, gp_pkg::RESP_OKAY);
  endtask

  task automatic t_reset_mid();
    wr(gp_pkg::OFS_DRIVE, 32'hc3, gp_pkg::RESP_OKAY);
    wr(gp_pkg::OFS_DIRECTION, 32'h0f, gp_pkg::RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    #1;
    chk("oe in reset", 32'h0, 32'(pad_oe));
    chk("pullup in reset", 32'h0, 32'(pad_pullup));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("dir after reset", gp_pkg::OFS_DIRECTION, 32'h0);
  endtask

  task automatic t_sleep();
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    wr(gp_pkg::OFS_INT_SENSE, 32'(gp_pkg::SENSE_ANY_CHANGE), gp_pkg::RESP_OKAY);
    wr(gp_pkg::OFS_INT_ENABLE, 32'h02, gp_pkg::RESP_OKAY);
    for (int m = 0; m < 7; m++) begin
      wr(gp_pkg::OFS_CONTROL, 32'(m) << 1, gp_pkg::RESP_OKAY);
      rchk("clamp", gp_pkg::OFS_INPUT, (m >= 3) ? 32'h02 : 32'hff);
    end
    wr(gp_pkg::OFS_CONTROL, 32'h6, gp_pkg::RESP_OKAY);
    wr(gp_pkg::OFS_INT_FLAG, 32'hff, gp_pkg::RESP_OKAY);
    wr(gp_pkg::OFS_CONTROL, 32'h0, gp_pkg::RESP_OKAY);
    repeat (4) @(posedge aclk);
    rchk("wake flag", gp_pkg::OFS_INT_FLAG, 32'h01);
  endtask

  // Falling sense on pin 2, rising sense on pin 3, level on the rest
  task automatic t_edges();
    wr(gp_pkg::OFS_INT_SENSE, 32'he0, gp_pkg::RESP_OKAY);
    wr(gp_pkg::OFS_INT_FLAG, 32'hff, gp_pkg::RESP_OKAY);
    @(posedge aclk);
    ext_val <= 8'hf3;
    repeat (4) @(posedge aclk);
    rchk("falling flag", gp_pkg::OFS_INT_FLAG, 32'h04);
    wr(gp_pkg::OFS_INT_FLAG, 32'hff, gp_pkg::RESP_OKAY);
    @(posedge aclk);
    ext_val <= 8'hff;
    repeat (4) @(posedge aclk);
    rchk("rising flag", gp_pkg::OFS_INT_FLAG, 32'h08);
  endtask

  task automatic t_unmapped();
    wr(32'h1c, 32'hff, gp_pkg::RESP_SLVERR);
    rdr(32'h1c, gp_pkg::RESP_SLVERR);
    chk("unmapped data", 32'h0, rd);
    rchk("no side effect", gp_pkg::OFS_DIRECTION, 32'h0);
    wr(gp_pkg::OFS_INPUT, 32'h0, gp_pkg::RESP_OKAY);
    rchk("input ignored", gp_pkg::OFS_INPUT, 32'hff);
  endtask

  // ****************************************
  // Clock, sequence and watchdog
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    ext_val = '0;
    ext_en = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals();
    t_pin_table();
    t_reset_mid();
    t_sleep();
    t_edges();
    t_unmapped();
    give_verdict();
  end

  // The scenarios need a few hundred cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    give_verdict();
  end
endmodule
